// [include/csu_pkg.sv]
// constants, field layouts and states of the chip-select and internal ram unit
// assumes a 20-bit memory address, 16-bit data path and a 32-bit wishbone bus
package csu_pkg;
	// ==========================================
	// widths
	localparam int ADDR_W = 20;
	localparam int CTL_W = 16;
	localparam int PER_W = 17;
	localparam int IRAM_W = 10;
	localparam int REF_W = 24;
	// ==========================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_UPPER = 8'h00;
	localparam logic [7:0] OFS_LOW = 8'h04;
	localparam logic [7:0] OFS_MID = 8'h08;
	localparam logic [7:0] OFS_PER = 8'h0C;
	localparam logic [7:0] OFS_IRAM = 8'h10;
	localparam logic [7:0] OFS_REF = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	// ==========================================
	// fields of upper, low and midrange control
	localparam int WAIT_LSB = 0;
	localparam int IGN_RDY_BIT = 2;
	localparam int DA_BIT = 7;
	localparam int BND_LSB = 8;
	// fields of peripheral control
	localparam int PBASE_LSB = 0;
	localparam int PIO_BIT = 9;
	localparam int PLWAIT_LSB = 10;
	localparam int PLIGN_BIT = 13;
	localparam int PUWAIT_LSB = 14;
	localparam int PUIGN_BIT = 16;
	// fields of internal ram map control
	localparam int IBASE_LSB = 0;
	localparam int IEN_BIT = 8;
	localparam int ISR_BIT = 9;
	// fields of refresh control
	localparam int RINT_LSB = 0;
	localparam int REN_BIT = 16;
	localparam int RBASE_LSB = 17;
	// ==========================================
	// values after reset
	localparam logic [CTL_W-1:0] UPPER_RESET = 16'h7803;
	localparam logic [CTL_W-1:0] LOW_RESET = 16'h0000;
	localparam logic [CTL_W-1:0] MID_RESET = 16'h0000;
	localparam logic [PER_W-1:0] PER_RESET = 17'h00000;
	localparam logic [IRAM_W-1:0] IRAM_RESET = 10'h000;
	localparam logic [REF_W-1:0] REF_RESET = 24'h000000;
	// ==========================================
	// bus cycle states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_T1 = 3'b001,
		ST_T2 = 3'b010,
		ST_T3 = 3'b011,
		ST_TW = 3'b100,
		ST_T4 = 3'b101,
		ST_HOLD = 3'b110
	} bus_state_type;
	// three-bit wait code of the lower peripheral selects
	function automatic logic [3:0] wait_cycles(input logic [2:0] code);
		case (code)
			3'h4: wait_cycles = 4'h5;
			3'h5: wait_cycles = 4'h7;
			3'h6: wait_cycles = 4'h9;
			3'h7: wait_cycles = 4'hF;
			default: wait_cycles = {2'h0, code[1:0]};
		endcase
	endfunction
endpackage

// [include/decode_if.sv]
// decoder configuration, current cycle address and the resulting hits
// assumes the controller drives configuration and address, the decoder answers
`timescale 1ns/1ps
`default_nettype none
interface decode_if;
	import csu_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic io;
	logic refresh;
	logic [CTL_W-1:0] upper_ctl;
	logic [CTL_W-1:0] low_ctl;
	logic [CTL_W-1:0] mid_ctl;
	logic [PER_W-1:0] per_ctl;
	logic [IRAM_W-1:0] iram_ctl;
	logic low_en;
	logic mid_en;
	logic per_en;
	logic ram_off;
	logic upper_hit;
	logic low_hit;
	logic [3:0] mid_hit;
	logic [6:0] per_hit;
	logic iram_hit;
	logic [3:0] wait_n;
	logic ready_req;
	modport ctrl (output addr, io, refresh, upper_ctl, low_ctl, mid_ctl, per_ctl, iram_ctl,
		low_en, mid_en, per_en, ram_off,
		input upper_hit, low_hit, mid_hit, per_hit, iram_hit, wait_n, ready_req);
	modport dec (input addr, io, refresh, upper_ctl, low_ctl, mid_ctl, per_ctl, iram_ctl,
		low_en, mid_en, per_en, ram_off,
		output upper_hit, low_hit, mid_hit, per_hit, iram_hit, wait_n, ready_req);
endinterface
`default_nettype wire

// [design/addr_decoder.sv]
// region decode: which selects hit the current address, and its wait and ready
// assumes stable configuration and address from the controller, same clock
`timescale 1ns/1ps
`default_nettype none
module addr_decoder (
	decode_if.dec d
);
	import csu_pkg::*;
	// ==========================================
	// region compares and wait selection
	always_comb
	begin
		d.upper_hit = !d.io && !d.refresh && (d.addr[19:13] >= d.upper_ctl[BND_LSB +: 7]);
		d.low_hit = d.low_en && !d.io && !d.refresh && (d.addr[19:17] == 3'h0)
			&& (d.addr[16:10] <= d.low_ctl[BND_LSB +: 7]);
		d.mid_hit = 4'h0;
		if (d.mid_en && !d.io && (d.addr[19:13] == d.mid_ctl[BND_LSB +: 7]))
		begin
			d.mid_hit[d.addr[12:11]] = 1'b1;
		end
		// seven 256-byte slots, slot four has no pin but keeps its wait logic
		d.per_hit = 7'h00;
		if (d.per_en && (d.addr[10:8] != 3'h7)
			&& (d.per_ctl[PIO_BIT] ? (d.io && d.addr[19:16] == 4'h0
			&& d.addr[15:11] == d.per_ctl[PBASE_LSB +: 5])
			: (!d.io && d.addr[19:11] == d.per_ctl[PBASE_LSB +: 9])))
		begin
			d.per_hit[d.addr[10:8]] = 1'b1;
		end
		d.iram_hit = d.iram_ctl[IEN_BIT] && !d.ram_off && !d.io && !d.refresh
			&& (d.addr[19:15] == d.iram_ctl[IBASE_LSB +: 5]);
		// internal ram wins: zero waits, ready ignored
		d.wait_n = 4'h0;
		d.ready_req = 1'b0;
		if (d.iram_hit)
		begin
			d.wait_n = 4'h0;
		end
		else if (d.upper_hit)
		begin
			d.wait_n = {2'h0, d.upper_ctl[WAIT_LSB +: 2]};
			d.ready_req = !d.upper_ctl[IGN_RDY_BIT];
		end
		else if (d.low_hit)
		begin
			d.wait_n = {2'h0, d.low_ctl[WAIT_LSB +: 2]};
			d.ready_req = !d.low_ctl[IGN_RDY_BIT];
		end
		else if (|d.mid_hit)
		begin
			d.wait_n = {2'h0, d.mid_ctl[WAIT_LSB +: 2]};
			d.ready_req = !d.mid_ctl[IGN_RDY_BIT];
		end
		else if (|d.per_hit[6:5])
		begin
			d.wait_n = {2'h0, d.per_ctl[PUWAIT_LSB +: 2]};
			d.ready_req = !d.per_ctl[PUIGN_BIT];
		end
		else if (|d.per_hit[4:0])
		begin
			d.wait_n = wait_cycles(d.per_ctl[PLWAIT_LSB +: 3]);
			d.ready_req = !d.per_ctl[PLIGN_BIT];
		end
		else
		begin
			d.ready_req = 1'b1;
		end
	end
endmodule
`default_nettype wire

// [design/onchip_ram.sv]
// on-chip ram, one word per 16-bit location, byte write lanes, registered read
// assumes the controller presents address and lane enables on the same clock
`timescale 1ns/1ps
`default_nettype none
module onchip_ram #(
	parameter int WORDS = 16384,
	parameter int AW = 14
) (
	input wire logic clk_i,
	input wire logic [1:0] we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [15:0] wdata_i,
	output logic [15:0] rdata_o
);
	logic [15:0] mem [WORDS];
	// ==========================================
	// byte lanes written independently, read one clock later
	always_ff @(posedge clk_i)
	begin
		if (we_i[0])
		begin
			mem[addr_i][7:0] <= wdata_i[7:0];
		end
		if (we_i[1])
		begin
			mem[addr_i][15:8] <= wdata_i[15:8];
		end
		rdata_o <= mem[addr_i];
	end
endmodule
`default_nettype wire

// [design/chip_select_unit.sv]
// chip-select unit with internal ram, refresh requester and hold arbiter
// assumes a classic wishbone master, a cpu-side request port on clk_i, async pins
// What this block does
// - upper select on after reset, three waits
// - upper region always ends at top address
// - address drive disable floats bus in address phase
// - address drive disable clears at reset
// - low select off until programmed, starts zero
// - midrange/peripheral late timing, upper/low early
// - seven peripheral selects, fifth has no pin
// - peripheral selects off until enabled
// - peripheral wait ranges, lower adds 5/7/9/15
// - each peripheral select spans 256 bytes
// - 32 kbyte zero-wait internal ram
// - ram base on 32k boundary, zero allowed
// - overlap: both select, read internal, write both
// - strobes and write data visible on ram access
// - disable strap sends ram window external
// - show-read by strap or bit, either one turns it on
// - show-read drives address then ram data
// - refresh read uses matching non-upper/low select
// - pending refresh drops hold acknowledge
// - refresh above hold in priority
// - two-bit wait field per select, three-bit for lower peripherals
// - internal ram ignores ready, zero waits
`timescale 1ns/1ps
`default_nettype none
module chip_select_unit (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic req_i,
	input wire logic [csu_pkg::ADDR_W-1:0] req_addr_i,
	input wire logic req_io_i,
	input wire logic req_we_i,
	input wire logic [1:0] req_be_i,
	input wire logic [15:0] req_wdata_i,
	output logic done_o,
	output logic [15:0] rdata_o,
	input wire logic async_ready_input_i,
	input wire logic sync_ready_input_i,
	input wire logic hold_request_i,
	input wire logic ram_disable_strap_n_i,
	input wire logic show_read_strap_n_i,
	input wire logic [15:0] ad_i,
	output logic [15:0] ad_o,
	output logic ad_oe_n_o,
	output logic [csu_pkg::ADDR_W-1:0] nonmuxed_address_bus_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic upper_memory_select_n_o,
	output logic low_memory_select_n_o,
	output logic [3:0] midrange_selects_n_o,
	output logic [1:0] upper_peripheral_selects_n_o,
	output logic [3:0] lower_peripheral_selects_n_o,
	output logic hold_acknowledge_o
);
	import csu_pkg::*;
	bus_state_type state_q;
	logic [CTL_W-1:0] upper_ctl_q, low_ctl_q, mid_ctl_q;
	logic [PER_W-1:0] per_ctl_q;
	logic [IRAM_W-1:0] iram_ctl_q;
	logic [REF_W-1:0] ref_ctl_q;
	logic low_en_q, mid_en_q, per_en_q;
	logic [20:0] sync1_q, sync2_q;
	logic ram_off_q, show_strap_q;
	logic [ADDR_W-1:0] cyc_addr_q;
	logic cyc_io_q, cyc_we_q, cyc_ref_q, iram_q, rdy_req_q;
	logic [1:0] cyc_be_q;
	logic [15:0] cyc_wdata_q;
	logic [3:0] wait_q;
	logic [15:0] ref_cnt_q;
	logic [12:0] ref_row_q;
	logic ref_pend_q;
	logic [15:0] ram_rdata;
	logic [1:0] ram_we;
	logic ready_s, hold_s, show_on, active, late, da_block, ref_take, wb_hit;
	logic [31:0] wmask;
	decode_if dec ();

	// ==========================================
	// pin synchronisers and straps
	// two flops on every pin; only the second stage is read
	always_ff @(posedge clk_i)
	begin
		sync1_q <= {ad_i, show_read_strap_n_i, ram_disable_strap_n_i, hold_request_i,
			sync_ready_input_i, async_ready_input_i};
		sync2_q <= sync1_q;
	end
	assign ready_s = sync2_q[0] | sync2_q[1];
	assign hold_s = sync2_q[2];

	// straps follow the pins while reset is held, frozen after release
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ram_off_q <= !sync2_q[3];
			show_strap_q <= !sync2_q[4];
		end
	end
	assign show_on = show_strap_q | iram_ctl_q[ISR_BIT];

	// ==========================================
	// decoder and ram
	assign dec.addr = cyc_addr_q;
	assign dec.io = cyc_io_q;
	assign dec.refresh = cyc_ref_q;
	assign dec.upper_ctl = upper_ctl_q;
	assign dec.low_ctl = low_ctl_q;
	assign dec.mid_ctl = mid_ctl_q;
	assign dec.per_ctl = per_ctl_q;
	assign dec.iram_ctl = iram_ctl_q;
	assign dec.low_en = low_en_q;
	assign dec.mid_en = mid_en_q;
	assign dec.per_en = per_en_q;
	assign dec.ram_off = ram_off_q;
	addr_decoder u_dec (
		.d(dec.dec)
	);

	// ram writes land in t3 whether or not an external select overlaps
	assign ram_we = (state_q == ST_T3 && iram_q && cyc_we_q) ? cyc_be_q : 2'h0;
	onchip_ram u_ram (
		.clk_i(clk_i),
		.we_i(ram_we),
		.addr_i(cyc_addr_q[14:1]),
		.wdata_i(cyc_wdata_q),
		.rdata_o(ram_rdata)
	);

	// ==========================================
	// wishbone register file
	assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	// byte-lane merge; an enable bit is set by any write to its register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			upper_ctl_q <= UPPER_RESET;
			low_ctl_q <= LOW_RESET;
			mid_ctl_q <= MID_RESET;
			per_ctl_q <= PER_RESET;
			iram_ctl_q <= IRAM_RESET;
			ref_ctl_q <= REF_RESET;
			low_en_q <= 1'b0;
			mid_en_q <= 1'b0;
			per_en_q <= 1'b0;
		end
		else if (wb_hit && wb_we_i)
		begin
			if (wb_adr_i == OFS_UPPER)
			begin
				upper_ctl_q <= CTL_W'((wb_dat_i & wmask) | ({16'h0, upper_ctl_q} & ~wmask));
			end
			else if (wb_adr_i == OFS_LOW)
			begin
				low_ctl_q <= CTL_W'((wb_dat_i & wmask) | ({16'h0, low_ctl_q} & ~wmask));
				low_en_q <= 1'b1;
			end
			else if (wb_adr_i == OFS_MID)
			begin
				mid_ctl_q <= CTL_W'((wb_dat_i & wmask) | ({16'h0, mid_ctl_q} & ~wmask));
				mid_en_q <= 1'b1;
			end
			else if (wb_adr_i == OFS_PER)
			begin
				per_ctl_q <= PER_W'((wb_dat_i & wmask) | ({15'h0, per_ctl_q} & ~wmask));
				per_en_q <= 1'b1;
			end
			else if (wb_adr_i == OFS_IRAM)
			begin
				iram_ctl_q <= IRAM_W'((wb_dat_i & wmask) | ({22'h0, iram_ctl_q} & ~wmask));
			end
			else if (wb_adr_i == OFS_REF)
			begin
				ref_ctl_q <= REF_W'((wb_dat_i & wmask) | ({8'h0, ref_ctl_q} & ~wmask));
			end
		end
	end

	// ack one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end
		else
		begin
			wb_ack_o <= wb_hit;
			if (wb_adr_i == OFS_UPPER)
			begin
				wb_dat_o <= {16'h0, upper_ctl_q};
			end
			else if (wb_adr_i == OFS_LOW)
			begin
				wb_dat_o <= {16'h0, low_ctl_q};
			end
			else if (wb_adr_i == OFS_MID)
			begin
				wb_dat_o <= {16'h0, mid_ctl_q};
			end
			else if (wb_adr_i == OFS_PER)
			begin
				wb_dat_o <= {15'h0, per_ctl_q};
			end
			else if (wb_adr_i == OFS_IRAM)
			begin
				wb_dat_o <= {22'h0, iram_ctl_q};
			end
			else if (wb_adr_i == OFS_REF)
			begin
				wb_dat_o <= {8'h0, ref_ctl_q};
			end
			else if (wb_adr_i == OFS_STAT)
			begin
				wb_dat_o <= {24'h0, hold_acknowledge_o, ref_pend_q, show_on, ram_off_q,
					1'b0, state_q};
			end
			else
			begin
				wb_dat_o <= 32'h0;
			end
		end
	end

	// ==========================================
	// refresh requester
	assign ref_take = (state_q == ST_IDLE) && ref_pend_q;

	// a new request raised while the old one is taken wins over the clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ref_cnt_q <= 16'h0;
			ref_pend_q <= 1'b0;
			ref_row_q <= 13'h0;
		end
		else
		begin
			if (ref_take)
			begin
				ref_row_q <= ref_row_q + 13'h1;
			end
			if (ref_ctl_q[REN_BIT] && ref_cnt_q == 16'h0)
			begin
				ref_cnt_q <= ref_ctl_q[RINT_LSB +: 16];
				ref_pend_q <= 1'b1;
			end
			else
			begin
				if (ref_ctl_q[REN_BIT])
				begin
					ref_cnt_q <= ref_cnt_q - 16'h1;
				end
				if (ref_take)
				begin
					ref_pend_q <= 1'b0;
				end
			end
		end
	end

	// ==========================================
	// bus cycle sequencer and hold arbiter
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_q <= ST_IDLE;
			cyc_addr_q <= '0;
			cyc_io_q <= 1'b0;
			cyc_we_q <= 1'b0;
			cyc_ref_q <= 1'b0;
			cyc_be_q <= 2'h0;
			cyc_wdata_q <= 16'h0;
			wait_q <= 4'h0;
			rdy_req_q <= 1'b0;
			iram_q <= 1'b0;
			hold_acknowledge_o <= 1'b0;
			done_o <= 1'b0;
			rdata_o <= 16'h0;
		end
		else
		begin
			done_o <= (state_q == ST_T4) && !cyc_ref_q;
			case (state_q)
				ST_IDLE:
				begin
					if (ref_pend_q)
					begin
						// refresh first, then hold, then the cpu
						cyc_addr_q <= {ref_ctl_q[RBASE_LSB +: 7], ref_row_q};
						cyc_io_q <= 1'b0;
						cyc_we_q <= 1'b0;
						cyc_ref_q <= 1'b1;
						state_q <= ST_T1;
					end
					else if (hold_s)
					begin
						hold_acknowledge_o <= 1'b1;
						state_q <= ST_HOLD;
					end
					else if (req_i && !done_o)
					begin
						cyc_addr_q <= req_addr_i;
						cyc_io_q <= req_io_i;
						cyc_we_q <= req_we_i;
						cyc_be_q <= req_be_i;
						cyc_wdata_q <= req_wdata_i;
						cyc_ref_q <= 1'b0;
						state_q <= ST_T1;
					end
				end
				ST_T1:
				begin
					state_q <= ST_T2;
				end
				ST_T2:
				begin
					wait_q <= dec.wait_n;
					rdy_req_q <= dec.ready_req;
					iram_q <= dec.iram_hit;
					state_q <= ST_T3;
				end
				ST_T3, ST_TW:
				begin
					// programmed waits run out before ready is looked at
					if (wait_q != 4'h0)
					begin
						wait_q <= wait_q - 4'h1;
						state_q <= ST_TW;
					end
					else if (rdy_req_q && !ready_s)
					begin
						state_q <= ST_TW;
					end
					else
					begin
						state_q <= ST_T4;
					end
				end
				ST_T4:
				begin
					rdata_o <= iram_q ? ram_rdata : sync2_q[20:5];
					state_q <= ST_IDLE;
				end
				ST_HOLD:
				begin
					// master must drop its request before refresh can run
					hold_acknowledge_o <= hold_s && !ref_pend_q;
					if (!hold_s)
					begin
						state_q <= ST_IDLE;
					end
				end
				default:
				begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================
	// pin drive, one clock behind the sequencer
	assign active = (state_q != ST_IDLE) && (state_q != ST_HOLD);
	assign late = active && (state_q != ST_T1);
	assign da_block = (dec.upper_hit && upper_ctl_q[DA_BIT])
		|| (dec.low_hit && low_ctl_q[DA_BIT]);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			upper_memory_select_n_o <= 1'b1;
			low_memory_select_n_o <= 1'b1;
			midrange_selects_n_o <= 4'hF;
			upper_peripheral_selects_n_o <= 2'h3;
			lower_peripheral_selects_n_o <= 4'hF;
			nonmuxed_address_bus_o <= '0;
			ad_o <= 16'h0;
			ad_oe_n_o <= 1'b1;
			rd_n_o <= 1'b1;
			wr_n_o <= 1'b1;
		end
		else
		begin
			upper_memory_select_n_o <= !(active && dec.upper_hit);
			low_memory_select_n_o <= !(active && dec.low_hit);
			midrange_selects_n_o <= ~(dec.mid_hit & {4{late}});
			upper_peripheral_selects_n_o <= ~(dec.per_hit[6:5] & {2{late}});
			lower_peripheral_selects_n_o <= ~(dec.per_hit[3:0] & {4{late}});
			nonmuxed_address_bus_o <= cyc_addr_q;
			rd_n_o <= !(late && !cyc_we_q);
			wr_n_o <= !(late && cyc_we_q);
			if (state_q == ST_T1)
			begin
				ad_o <= cyc_addr_q[15:0];
				ad_oe_n_o <= da_block;
			end
			else if (state_q == ST_T2 && !cyc_we_q && dec.iram_hit && show_on && !da_block)
			begin
				// show read keeps the address up for a second cycle, data follows
				ad_o <= cyc_addr_q[15:0];
				ad_oe_n_o <= 1'b0;
			end
			else if (late && cyc_we_q)
			begin
				ad_o <= cyc_wdata_q;
				ad_oe_n_o <= 1'b0;
			end
			else if (late && state_q != ST_T2 && iram_q && show_on)
			begin
				ad_o <= ram_rdata;
				ad_oe_n_o <= 1'b0;
			end
			else
			begin
				ad_oe_n_o <= 1'b1;
			end
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence zero_wait_s;
		state_q == ST_T3 ##1 state_q == ST_T4;
	endsequence
	upper_reset_a: assert property ($fell(rst_i) |-> upper_ctl_q == UPPER_RESET)
		else $error("upper control not at reset value");
	da_reset_a: assert property ($fell(rst_i) |-> !upper_ctl_q[DA_BIT])
		else $error("address drive disable set after reset");
	low_off_a: assert property (!$past(low_en_q) |-> low_memory_select_n_o)
		else $error("low select active before programming");
	per_off_a: assert property (!$past(per_en_q) |->
		(&lower_peripheral_selects_n_o) && (&upper_peripheral_selects_n_o))
		else $error("peripheral select active before enable");
	da_float_a: assert property (state_q == ST_T1 && dec.upper_hit && upper_ctl_q[DA_BIT]
		|=> ad_oe_n_o && !upper_memory_select_n_o)
		else $error("bus driven in address phase with drive disabled");
	iram_wait_a: assert property (state_q == ST_T2 && dec.iram_hit |=> zero_wait_s)
		else $error("internal ram access not zero wait");
	refresh_hold_a: assert property (state_q == ST_HOLD && ref_pend_q
		|=> !hold_acknowledge_o)
		else $error("hold kept while refresh pending");
	show_read_a: assert property (state_q == ST_T3 && iram_q && !cyc_we_q && show_on
		|=> !ad_oe_n_o && ad_o == $past(ram_rdata))
		else $error("show read data not driven");
	ref_first_a: assert property (state_q == ST_IDLE && ref_pend_q && hold_s
		|=> state_q == ST_T1 && cyc_ref_q)
		else $error("hold taken ahead of refresh");
	strobe_ram_a: assert property (state_q == ST_T3 && iram_q && cyc_we_q
		|-> ram_we == cyc_be_q ##1 !wr_n_o)
		else $error("ram write without external strobe");
endmodule
`default_nettype wire

// [verif/ext_side.sv]
// far side of the unit: external memory data, ready and a hold master
// assumes the unit's pins on the same clock
`timescale 1ns/1ps
`default_nettype none
module ext_side (
	input wire logic clk_i,
	input wire logic rd_n_i,
	input wire logic oe_n_i,
	input wire logic [15:0] dout_i,
	input wire logic hold_want_i,
	input wire logic hold_ack_i,
	output logic [15:0] ad_o,
	output logic ready_o,
	output logic hold_request_o
);
	logic [15:0] fill_q = 16'h0000;
	logic ack_q = 1'b0;
	logic [1:0] gap_q = 2'h0;
	// ========
	// bus wire: unit data, else memory data, else churn so stale values never pass
	always_comb ad_o = !oe_n_i ? dout_i : (!rd_n_i ? 16'hA5A5 : fill_q);
	always_ff @(posedge clk_i) fill_q <= ~ad_o;
	// prompt memory, always ready
	assign ready_o = 1'b1;
	// lost ack means a refresh waits: let go of hold for two clocks
	always_ff @(posedge clk_i)
	begin
		ack_q <= hold_ack_i;
		if (ack_q && !hold_ack_i)
			gap_q <= 2'h2;
		else if (gap_q != 2'h0)
			gap_q <= gap_q - 2'h1;
	end
	assign hold_request_o = hold_want_i && (gap_q == 2'h0);
endmodule
`default_nettype wire

// [verif/chip_select_unit_tb_top.sv]
// bench: registers, decode, internal ram and hold of the chip-select unit
// assumes csu_pkg, the design and ext_side are compiled first
`timescale 1ns/1ps
`default_nettype none
module chip_select_unit_tb_top;
	import csu_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, we = 1'b0, req = 1'b0, rwe = 1'b0, want = 1'b0, rio = 1'b0;
	logic imd_n = 1'b1, srs_n = 1'b1;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, wbq, rd32;
	logic [19:0] ra = 20'h0, nab;
	logic [15:0] rwd = 16'h0, rdq, rd16, ado, adi;
	logic ack, done, oe_n, rd_n, wr_n, up_n, lo_n, hreq, hack, rdy;
	logic [3:0] mid_n, pl_n;
	logic [1:0] pu_n;
	logic [11:0] seen;
	logic drv, shown, wrs;
	int err_count = 0, num_checks = 0, ticks = 0, n;
	logic [19:0] ta [10] = '{20'h40000, 20'h40800, 20'h80000, 20'h800FF, 20'h80300,
		20'h80400, 20'h80500, 20'h80600, 20'hEFFFE, 20'hFFFFE};
	logic [11:0] ts [10] = '{12'h040, 12'h080, 12'h001, 12'h001, 12'h008,
		12'h000, 12'h010, 12'h020, 12'h000, 12'h800};
	int tn [10] = '{7, 7, 11, 11, 11, 11, 8, 8, 6, 6};
	chip_select_unit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(wbq),
		.wb_ack_o(ack), .req_i(req), .req_addr_i(ra), .req_io_i(rio), .req_we_i(rwe),
		.req_be_i(2'h3), .req_wdata_i(rwd), .done_o(done), .rdata_o(rdq),
		.async_ready_input_i(rdy), .sync_ready_input_i(rdy), .hold_request_i(hreq),
		.ram_disable_strap_n_i(imd_n), .show_read_strap_n_i(srs_n), .ad_i(adi), .ad_o(ado),
		.ad_oe_n_o(oe_n), .nonmuxed_address_bus_o(nab), .rd_n_o(rd_n), .wr_n_o(wr_n),
		.upper_memory_select_n_o(up_n), .low_memory_select_n_o(lo_n),
		.midrange_selects_n_o(mid_n), .upper_peripheral_selects_n_o(pu_n),
		.lower_peripheral_selects_n_o(pl_n), .hold_acknowledge_o(hack));
	ext_side far (.clk_i(clk_i), .rd_n_i(rd_n), .oe_n_i(oe_n), .dout_i(ado),
		.hold_want_i(want), .hold_ack_i(hack), .ad_o(adi), .ready_o(rdy), .hold_request_o(hreq));
	// ========
	// clock and hang guard
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		ticks++;
		if (ticks == 20000)
		begin
			err_count++;
			wrap_up();
		end
	end
	// ========
	// tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic reset();
		rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	// classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		rd32 = wbq;
		cyc <= 1'b0;
	endtask
	// one cpu cycle; pins are watched on falling edges, where they have settled
	task automatic cpu(input logic w, input logic [19:0] a, input logic [15:0] d);
		@(posedge clk_i);
		req <= 1'b1;
		rwe <= w;
		ra <= a;
		rwd <= d;
		{seen, drv, shown, wrs, n} = '0;
		do
		begin
			@(negedge clk_i);
			n++;
			seen = seen | ~{up_n, lo_n, mid_n, pu_n, pl_n};
			drv = drv | !oe_n;
			shown = shown | (!oe_n && ado === d);
			wrs = wrs | !wr_n;
		end
		while (done !== 1'b1);
		rd16 = rdq;
		@(posedge clk_i);
		req <= 1'b0;
	endtask
	// bounded wait for hold ack (0) or the first midrange select (1)
	task automatic await(input logic m, input logic v);
		int k;
		k = 0;
		while ((m ? mid_n[0] : hack) !== v && k < 400)
		begin
			@(negedge clk_i);
			k++;
		end
		chk("await", v, m ? mid_n[0] : hack);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ========
	// test sequence
	initial
	begin
		reset();
		wb(1'b0, OFS_UPPER, 32'h0);
		chk("upper ctl", 32'h7803, rd32);
		wb(1'b0, OFS_PER, 32'h0);
		chk("per ctl", 32'h0, rd32);
		cpu(1'b0, 20'hFFFF0, 16'h0);
		chk("boot sel", 12'h800, seen);
		chk("boot len", 9, n);
		chk("bus drive", 1, drv);
		chk("ext data", 16'hA5A5, rd16);
		chk("addr bus", 20'hFFFF0, nab);
		wb(1'b1, OFS_UPPER, 32'h7884);
		wb(1'b1, OFS_MID, 32'h2005);
		wb(1'b1, OFS_PER, 32'h1B100);
		cpu(1'b0, 20'hFFFF0, 16'h0);
		chk("float", 0, drv);
		chk("upper len", 6, n);
		for (int i = 0; i < 10; i++)
		begin
			cpu(1'b0, ta[i], 16'h0);
			chk("selects", ts[i], seen);
			if (tn[i] != 0)
				chk("length", tn[i], n);
		end
		wb(1'b1, OFS_PER, 32'h1B204);
		rio <= 1'b1;
		cpu(1'b0, 20'h02100, 16'h0);
		rio <= 1'b0;
		chk("io sel", 12'h002, seen);
		chk("io len", 11, n);
		wb(1'b1, OFS_IRAM, 32'h100);
		wb(1'b1, OFS_LOW, 32'h0704);
		cpu(1'b1, 20'h00010, 16'h1234);
		chk("wr strobe", 1, wrs);
		chk("both sel", 12'h400, seen);
		cpu(1'b0, 20'h00010, 16'h1234);
		chk("ram data", 16'h1234, rd16);
		chk("ram len", 6, n);
		wb(1'b1, OFS_IRAM, 32'h300);
		cpu(1'b0, 20'h00010, 16'h1234);
		chk("shown", 1, shown);
		wb(1'b1, OFS_IRAM, 32'h101);
		cpu(1'b1, 20'h08002, 16'hBEEF);
		cpu(1'b0, 20'h08002, 16'hBEEF);
		chk("moved ram", 16'hBEEF, rd16);
		@(posedge clk_i);
		want <= 1'b1;
		await(1'b0, 1'b1);
		wb(1'b1, OFS_REF, 32'h410028);
		await(1'b0, 1'b0);
		await(1'b1, 1'b0);
		await(1'b0, 1'b1);
		@(posedge clk_i);
		want <= 1'b0;
		wb(1'b1, OFS_REF, 32'h0);
		imd_n <= 1'b0;
		srs_n <= 1'b0;
		reset();
		wb(1'b0, OFS_STAT, 32'h0);
		chk("straps", 32'h30, rd32);
		wrap_up();
	end
endmodule
`default_nettype wire
